/* File: src/dcdcc_control.sv */
// Overview of operation
// - passive diode mode disables bypass-switch control
// - bits 7:6 pick minimum switch pulse
// - bit 5 clear large, set small switches
// - sync bit aligns ADC tracking and SAR clock
// - bits 2:0 select output voltage target
// - reset value 0x21, usable without software
// - decoded at 0x97 page 0x0, all RW
// - clock-invert bit honoured only during sync
`timescale 1ns/1ps
module dcdcc_control
   import dcdcc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] sfr_addr,
   input wire logic [3:0] sfr_page,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_sel,
   input wire logic passive_diode_enable,
   input wire logic adc_sar_clock_invert,
   input wire logic dcdc_clk_en,
   output dcdcc_stage_s stage,
   output logic adc_track_en,
   output logic sar_clk_en
);
   // ---------------------------------------------
   // decode
   // ---------------------------------------------
   logic hit;
   logic [7:0] dcdc_control;

   assign hit = (sfr_addr == DCDCC_CTRL_ADDR) && (sfr_page == DCDCC_CTRL_PAGE);
   assign sfr_sel = hit & (sfr_wr | sfr_rd);

   // reserved bit stored as written; software keeps it zero
   dcdcc_field_reg #(
      .WIDTH(8),
      .RESET_VAL(DCDCC_CTRL_RESET)
   ) u_ctrl (
      .clk_sys(clk_sys),
      .rst(rst),
      .wr_en(hit & sfr_wr),
      .wr_data(sfr_wdata),
      .value(dcdc_control)
   );

   // read data registered; unmapped addresses read zero
   logic [7:0] sfr_rdata_r;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sfr_rdata_r <= 8'h00;
      end else if (sfr_rd) begin
         sfr_rdata_r <= hit ? dcdc_control : 8'h00;
      end
   end
   assign sfr_rdata = sfr_rdata_r;

   // ---------------------------------------------
   // power stage fields
   // ---------------------------------------------
   logic [1:0] pulse_code;
   logic [2:0] vout_code;
   logic [7:0] min_ns;
   logic sync_on;

   assign pulse_code = dcdc_control[DCDCC_MIN_PULSE_LSB +: 2];
   assign vout_code = dcdc_control[DCDCC_VOUT_SEL_LSB +: 3];
   assign sync_on = dcdc_control[DCDCC_SYNC_BIT];

   always_comb begin
      case (pulse_code)
         DCDCC_MIN_PULSE_20: min_ns = 8'(DCDCC_MIN_PULSE_20_NS);
         DCDCC_MIN_PULSE_40: min_ns = 8'(DCDCC_MIN_PULSE_40_NS);
         DCDCC_MIN_PULSE_80: min_ns = 8'(DCDCC_MIN_PULSE_80_NS);
         default: min_ns = 8'h00;
      endcase
   end

   always_comb begin
      stage.min_pulse_width_sel = pulse_code;
      stage.min_pulse_ns = min_ns;
      stage.switch_size_sel = dcdc_control[DCDCC_SWITCH_SIZE_BIT];
      stage.adc_sync_en = sync_on;
      stage.output_voltage_sel = vout_code;
      stage.vout_target_mv = DCDCC_VOUT_MV[vout_code];
      stage.bypass_ctrl_en = ~passive_diode_enable;
      // 0 means inverted; ignored outside sync
      stage.sar_clk_invert = sync_on & ~adc_sar_clock_invert;
   end

   // ---------------------------------------------
   // adc timing: track in quiet half, sar clock on converter clock
   // ---------------------------------------------
   logic phase_r;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         phase_r <= 1'b0;
      end else if (dcdc_clk_en) begin
         phase_r <= ~phase_r;
      end
   end

   // without sync the adc free-runs, tracking always allowed
   assign adc_track_en = sync_on ? (phase_r == stage.sar_clk_invert) : 1'b1;
   assign sar_clk_en = sync_on ? dcdc_clk_en : 1'b1;

   // ---------------------------------------------
   // checks: register access
   // ---------------------------------------------
   a_write_update: assert property (@(posedge clk_sys) disable iff (rst)
      hit && sfr_wr |=> dcdc_control == $past(sfr_wdata))
      else $error("control register missed write");
   a_hold_value: assert property (@(posedge clk_sys) disable iff (rst)
      !(hit && sfr_wr) |=> $stable(dcdc_control))
      else $error("control register changed without write");
   a_read_back: assert property (@(posedge clk_sys) disable iff (rst)
      sfr_rd && hit |=> sfr_rdata == $past(dcdc_control))
      else $error("read data wrong");
   // a miss must not leak the control value
   a_read_miss: assert property (@(posedge clk_sys) disable iff (rst)
      sfr_rd && !hit |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   // read data stands until the next read strobe
   a_read_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !sfr_rd |=> $stable(sfr_rdata))
      else $error("read data changed without read");
   a_sel_decode: assert property (@(posedge clk_sys) disable iff (rst)
      sfr_sel |-> sfr_addr == 8'h97 && sfr_page == 4'h0)
      else $error("select raised off the control address");
   // no disable here: the release edge itself is checked
   a_reset_val: assert property (@(posedge clk_sys)
      $fell(rst) |-> dcdc_control == 8'h21)
      else $error("reset value wrong");
   a_reset_read: assert property (@(posedge clk_sys)
      $fell(rst) |-> sfr_rdata == 8'h00)
      else $error("read data not cleared by reset");
   a_reset_stage: assert property (@(posedge clk_sys)
      $fell(rst) |-> stage.vout_target_mv == 12'h76C && stage.switch_size_sel && !stage.adc_sync_en)
      else $error("power stage defaults wrong after reset");

   // ---------------------------------------------
   // checks: field decode
   // ---------------------------------------------
   a_pulse_none: assert property (@(posedge clk_sys) disable iff (rst)
      (pulse_code == 2'h0) |-> stage.min_pulse_ns == 8'h00)
      else $error("minimum pulse not off");
   a_pulse_short: assert property (@(posedge clk_sys) disable iff (rst)
      (pulse_code == 2'h1) |-> stage.min_pulse_ns == 8'h14)
      else $error("short minimum pulse wrong");
   a_pulse_mid: assert property (@(posedge clk_sys) disable iff (rst)
      (pulse_code == 2'h2) |-> stage.min_pulse_ns == 8'h28)
      else $error("middle minimum pulse wrong");
   a_pulse_long: assert property (@(posedge clk_sys) disable iff (rst)
      (pulse_code == 2'h3) |-> stage.min_pulse_ns == 8'h50)
      else $error("minimum pulse mapping wrong");
   a_pulse_field: assert property (@(posedge clk_sys) disable iff (rst)
      hit && sfr_wr |=> stage.min_pulse_width_sel == $past(sfr_wdata[7:6]))
      else $error("pulse select not following write");
   a_switch_size: assert property (@(posedge clk_sys) disable iff (rst)
      hit && sfr_wr |=> stage.switch_size_sel == $past(sfr_wdata[5]))
      else $error("switch size not following write");
   a_sync_field: assert property (@(posedge clk_sys) disable iff (rst)
      hit && sfr_wr |=> stage.adc_sync_en == $past(sfr_wdata[3]))
      else $error("sync enable not following write");
   a_vout_low: assert property (@(posedge clk_sys) disable iff (rst)
      (vout_code == 3'h0) |-> stage.vout_target_mv == 12'h708)
      else $error("lowest voltage wrong");
   a_vout_map: assert property (@(posedge clk_sys) disable iff (rst)
      (vout_code == 3'h1) |-> stage.vout_target_mv == 12'h76C)
      else $error("voltage mapping wrong");
   a_vout_two: assert property (@(posedge clk_sys) disable iff (rst)
      (vout_code == 3'h2) |-> stage.vout_target_mv == 12'h7D0)
      else $error("voltage code two wrong");
   a_vout_three: assert property (@(posedge clk_sys) disable iff (rst)
      (vout_code == 3'h3) |-> stage.vout_target_mv == 12'h834)
      else $error("voltage code three wrong");
   a_vout_mid: assert property (@(posedge clk_sys) disable iff (rst)
      (vout_code == 3'h4) |-> stage.vout_target_mv == 12'h960)
      else $error("voltage code four wrong");
   a_vout_five: assert property (@(posedge clk_sys) disable iff (rst)
      (vout_code == 3'h5) |-> stage.vout_target_mv == 12'hA8C)
      else $error("voltage code five wrong");
   a_vout_six: assert property (@(posedge clk_sys) disable iff (rst)
      (vout_code == 3'h6) |-> stage.vout_target_mv == 12'hBB8)
      else $error("voltage code six wrong");
   a_vout_high: assert property (@(posedge clk_sys) disable iff (rst)
      (vout_code == 3'h7) |-> stage.vout_target_mv == 12'hCE4)
      else $error("highest voltage wrong");
   a_vout_field: assert property (@(posedge clk_sys) disable iff (rst)
      hit && sfr_wr |=> stage.output_voltage_sel == $past(sfr_wdata[2:0]))
      else $error("voltage select not following write");
   a_diode_mode: assert property (@(posedge clk_sys) disable iff (rst)
      stage.bypass_ctrl_en != passive_diode_enable)
      else $error("bypass control not off in passive mode");

   // ---------------------------------------------
   // checks: adc timing
   // ---------------------------------------------
   a_sync_track: assert property (@(posedge clk_sys) disable iff (rst)
      !sync_on |-> adc_track_en && sar_clk_en && !stage.sar_clk_invert)
      else $error("adc timing active without sync");
   a_sar_follow: assert property (@(posedge clk_sys) disable iff (rst)
      sync_on |-> sar_clk_en == dcdc_clk_en)
      else $error("sar clock not on converter clock");
   a_phase_step: assert property (@(posedge clk_sys) disable iff (rst)
      dcdc_clk_en |=> phase_r != $past(phase_r))
      else $error("switching phase not advancing");
   a_invert_sel: assert property (@(posedge clk_sys) disable iff (rst)
      sync_on |-> stage.sar_clk_invert == !adc_sar_clock_invert)
      else $error("sar clock inversion wrong during sync");

   // ---------------------------------------------
   // covers
   // ---------------------------------------------
   c_write_sync: cover property (@(posedge clk_sys) disable iff (rst) hit && sfr_wr && sfr_wdata[3]);
   c_passive: cover property (@(posedge clk_sys) disable iff (rst) passive_diode_enable);
   c_read: cover property (@(posedge clk_sys) disable iff (rst) hit && sfr_rd);
   c_max_v: cover property (@(posedge clk_sys) disable iff (rst) vout_code == 3'h7);
   c_inverted: cover property (@(posedge clk_sys) disable iff (rst) sync_on && !adc_sar_clock_invert);
endmodule

/* File: src/dcdcc_pkg.sv */
package dcdcc_pkg;

   // ---------------------------------------------
   // register map
   // ---------------------------------------------
   localparam logic [7:0] DCDCC_CTRL_ADDR = 8'h97;
   localparam logic [3:0] DCDCC_CTRL_PAGE = 4'h0;
   localparam logic [7:0] DCDCC_CTRL_RESET = 8'h21;

   // field positions
   localparam int DCDCC_MIN_PULSE_LSB = 6;
   localparam int DCDCC_SWITCH_SIZE_BIT = 5;
   localparam int DCDCC_RSVD_BIT = 4;
   localparam int DCDCC_SYNC_BIT = 3;
   localparam int DCDCC_VOUT_SEL_LSB = 0;
   localparam int DCDCC_INV_BIT = 4;

   // minimum pulse codes and times
   localparam logic [1:0] DCDCC_MIN_PULSE_NONE = 2'h0;
   localparam logic [1:0] DCDCC_MIN_PULSE_20 = 2'h1;
   localparam logic [1:0] DCDCC_MIN_PULSE_40 = 2'h2;
   localparam logic [1:0] DCDCC_MIN_PULSE_80 = 2'h3;
   localparam int DCDCC_MIN_PULSE_20_NS = 20;
   localparam int DCDCC_MIN_PULSE_40_NS = 40;
   localparam int DCDCC_MIN_PULSE_80_NS = 80;

   // output targets in millivolts
   localparam logic [11:0] DCDCC_VOUT_MV [8] = '{12'h708, 12'h76C, 12'h7D0, 12'h834,
                                               12'h960, 12'hA8C, 12'hBB8, 12'hCE4};

   // ---------------------------------------------
   // carrier to the power stage
   // ---------------------------------------------
   typedef struct packed {
      logic [1:0] min_pulse_width_sel;
      logic [7:0] min_pulse_ns;
      logic switch_size_sel;
      logic adc_sync_en;
      logic [2:0] output_voltage_sel;
      logic [11:0] vout_target_mv;
      logic bypass_ctrl_en;
      logic sar_clk_invert;
   } dcdcc_stage_s;

endpackage

/* File: src/dcdcc_field_reg.sv */
`timescale 1ns/1ps
module dcdcc_field_reg
   import dcdcc_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wr_data,
   output logic [WIDTH-1:0] value
);
   logic [WIDTH-1:0] value_r;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         value_r <= RESET_VAL;
      end else if (wr_en) begin
         value_r <= wr_data;
      end
   end

   assign value = value_r;
endmodule

/* File: tb/dcdcc_stage_model.sv */
`timescale 1ns/1ps
// converter clock: one pulse per 4 system clocks, free running
module dcdcc_stage_model
   import dcdcc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire dcdcc_stage_s stage,
   output logic dcdc_clk_en
);
   logic [1:0] div_r;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         div_r <= 2'h0;
      end else begin
         div_r <= div_r + 2'h1;
      end
   end
   assign dcdc_clk_en = (div_r == 2'h3);
endmodule

/* File: tb/dcdc_control_register_tb.sv */
`timescale 1ns/1ps
module dcdc_control_register_tb;
   import dcdcc_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, pde = 1'b0, inv = 1'b1;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d;
   logic [3:0] sfr_page = 4'h0;
   logic sfr_sel, adc_track_en, sar_clk_en, dcdc_clk_en;
   dcdcc_stage_s stage;
   int bad_count = 0, cmp_count = 0, cyc = 0, trk;
   // targets in millivolts, pulses in ns
   logic [11:0] mv [8] = '{12'h708, 12'h76C, 12'h7D0, 12'h834, 12'h960, 12'hA8C, 12'hBB8, 12'hCE4};
   logic [7:0] ns [4] = '{8'h00, 8'h14, 8'h28, 8'h50};
   always #25 clk_sys = ~clk_sys;
   dcdcc_control DUT (.clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .sfr_sel(sfr_sel), .passive_diode_enable(pde), .adc_sar_clock_invert(inv),
      .dcdc_clk_en(dcdc_clk_en), .stage(stage), .adc_track_en(adc_track_en), .sar_clk_en(sar_clk_en));
   dcdcc_stage_model u_stage (.clk_sys(clk_sys), .rst(rst), .stage(stage), .dcdc_clk_en(dcdc_clk_en));
   // ------------------------------
   // access tasks
   // ------------------------------
   task automatic chk(string n, logic [11:0] e, logic [11:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s exp %0h got %0h", n, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [3:0] p, logic [7:0] v);
      sfr_addr = a;
      sfr_page = p;
      sfr_wdata = v;
      sfr_wr = 1'b1;
      @(negedge clk_sys);
      sfr_wr = 1'b0;
      // idle cycle keeps back-to-back strobes apart
      @(negedge clk_sys);
   endtask
   task automatic rd(logic [7:0] a, logic [3:0] p, logic [7:0] e);
      sfr_addr = a;
      sfr_page = p;
      sfr_rd = 1'b1;
      #1 chk("sel", {11'h0, a == 8'h97 && p == 4'h0}, {11'h0, sfr_sel});
      @(negedge clk_sys);
      sfr_rd = 1'b0;
      chk("rdata", {4'h0, e}, {4'h0, sfr_rdata});
      @(negedge clk_sys);
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // whole run is under 200 cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         summarize();
      end
   end
   initial begin
      repeat (5) @(negedge clk_sys);
      rst = 1'b0;
      rd(8'h97, 4'h0, 8'h21);
      chk("vout", 12'h76C, stage.vout_target_mv);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         d = {i[1:0], i[2], 2'h0, i[2:0]};
         wr(8'h97, 4'h0, d);
         chk("vout", mv[i], stage.vout_target_mv);
         chk("vout_sel", {9'h0, i[2:0]}, {9'h0, stage.output_voltage_sel});
         chk("min_pulse", {4'h0, ns[i % 4]}, {4'h0, stage.min_pulse_ns});
         chk("pulse_sel", {10'h0, i[1:0]}, {10'h0, stage.min_pulse_width_sel});
         chk("switch_size", {11'h0, i[2]}, {11'h0, stage.switch_size_sel});
         rd(8'h97, 4'h0, d);
      end
      wr(8'h96, 4'h0, 8'hFF);
      wr(8'h97, 4'hF, 8'hFF);
      rd(8'h96, 4'h0, 8'h00);
      rd(8'h97, 4'hF, 8'h00);
      rd(8'h97, 4'h0, d);
      $display("test fields done");
      for (int j = 0; j < 2; j++) begin
         @(negedge clk_sys);
         pde = j[0];
         #1 chk("bypass", {11'h0, !j[0]}, {11'h0, stage.bypass_ctrl_en});
      end
      $display("test diode done");
      @(negedge clk_sys);
      wr(8'h97, 4'h0, 8'h08);
      chk("sync", 12'h001, {11'h0, stage.adc_sync_en});
      for (int j = 0; j < 2; j++) begin
         inv = j[0];
         trk = 0;
         repeat (8) begin
            @(negedge clk_sys);
            trk += adc_track_en;
            chk("sarclk", {11'h0, dcdc_clk_en}, {11'h0, sar_clk_en});
         end
         chk("track", 12'h004, trk[11:0]);
         chk("inv", {11'h0, !j[0]}, {11'h0, stage.sar_clk_invert});
      end
      inv = 1'b0;
      wr(8'h97, 4'h0, 8'h00);
      chk("sync", 12'h000, {11'h0, stage.adc_sync_en});
      chk("inv", 12'h000, {11'h0, stage.sar_clk_invert});
      chk("trk", 12'h001, {11'h0, adc_track_en & sar_clk_en});
      $display("test sync done");
      summarize();
   end
endmodule
